/* pkg/ctps_pkg.sv */
/*
  Shared constants for the card information tail and personality switch block:
  register offsets, field positions, reset values, tuple codes, timing and mode states.
  Assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
package ctps_pkg;

  // Clock and switch delay timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SWITCH_WAIT_NS = 10000;
  // Least time, so round up to whole cycles
  localparam int SWITCH_WAIT_CYC = (SWITCH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_CNT_W = 8;

  // Byte addresses on the APB bus
  localparam logic [11:0] ADDR_CFG_OPT = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CIS_BASE = 12'h100;
  localparam logic [11:0] ADDR_CIS_LAST = 12'h1fc;
  localparam int CIS_IDX_W = 6;
  localparam int CIS_MAX = 64;

  // Configuration option register layout
  localparam int SOFT_RESET_BIT = 7;
  localparam int LEVEL_IRQ_BIT = 6;
  localparam int FUNC_IDX_MSB = 5;
  localparam logic [7:0] CFG_OPT_RESET = 8'h00;

  // Status register layout
  localparam int STAT_PENDING_BIT = 0;
  localparam int STAT_SWITCHED_BIT = 1;

  // Tuple and string codes
  localparam logic [7:0] CODE_SYS_EVENT = 8'hc0;
  localparam logic [7:0] CODE_PHYS_DEV = 8'hc1;
  localparam logic [7:0] CODE_END_CHAIN = 8'hff;
  localparam logic [7:0] STR_TERM = 8'h00;
  localparam logic [7:0] STR_PAD = 8'hff;
  localparam int STR_MAX = 16;

  // Pin personality of the card
  typedef enum logic [1:0] {MODE_PCCARD, MODE_WAIT, MODE_CARD_IF} ctps_mode_e;

endpackage

/* design/ctps_cis_rom.sv */
/*
  Constant lookup of the card information tail: system event subtuple,
  physical device subtuple and end-of-chain tuple, one byte per index.
  Assumes names are left-justified in their packed parameters, first character highest.
*/
`timescale 1ns/10ps
module ctps_cis_rom
  import ctps_pkg::*;
#(
  // Arbitrary neutral names; a product overrides them
  parameter logic [8*ctps_pkg::STR_MAX-1:0] HOST_NAME = {"GENERIC_HOST", 32'h0},
  parameter int HOST_LEN = 12,
  parameter logic [8*ctps_pkg::STR_MAX-1:0] MOD_NAME = {"GENERIC_MODULE", 16'h0},
  parameter int MOD_LEN = 14
)
(
  // Byte lookup
  input wire logic [ctps_pkg::CIS_IDX_W-1:0] idx,
  output logic [7:0] data
);

  // One name subtuple: code, link, string, terminator, pad
  function automatic logic [7:0] sub_byte(input int k, input logic [7:0] code,
                                         input logic [8*STR_MAX-1:0] name, input int len);
    logic [7:0] b;
    b = STR_PAD;
    if (k == 0)
    begin
      b = code;
    end
    else if (k == 1)
    begin
      b = 8'(len + 2);
    end
    else if (k < len + 2)
    begin
      b = name[8*(STR_MAX-1-(k-2)) +: 8];
    end
    else if (k == len + 2)
    begin
      b = STR_TERM;
    end
    return b;
  endfunction

  // Chain order keeps the end tuple last; reads past it also return the end code
  always_comb
  begin
    int i;
    i = int'(idx);
    if (i < HOST_LEN + 4)
    begin
      data = sub_byte(i, CODE_SYS_EVENT, HOST_NAME, HOST_LEN);
    end
    else if (i < HOST_LEN + MOD_LEN + 8)
    begin
      data = sub_byte(i - HOST_LEN - 4, CODE_PHYS_DEV, MOD_NAME, MOD_LEN);
    end
    else
    begin
      data = CODE_END_CHAIN;
    end
  end

endmodule

/* design/ctps_top.sv */
/*
  APB slave holding the configuration option register, a status word and a
  read-only window onto the card information tail; times the switch from the
  PC Card personality to the card's own interface.
  Assumes a 10 MHz clock, a synchronous active-low reset and an APB master
  on the same clock; the switch outputs feed the card's pin multiplexer.
*/
`timescale 1ns/10ps
// Summary of operation
// - System event subtuple starts with code c0, link, host name strings.
// - Physical device subtuple starts with code c1, link, module name strings.
// - Each subtuple's second byte is its link, at least m-1.
// - First string basic coded; later strings alternate coding without escape.
// - Every string ends in zero; a short last string gets an ff pad.
// - Chain closes with end tuple ff; other tuples come before it.
// - Host sets level interrupt bit 6; card then uses level interrupts.
// - After a correct write the card waits 10 us before switching pins.
module ctps_top
  import ctps_pkg::*;
#(
  // Arbitrary neutral entry index and names; a product overrides them
  parameter logic [7:0] CFG_ENTRY_INDEX = 8'h01,
  parameter logic [8*ctps_pkg::STR_MAX-1:0] HOST_NAME = {"GENERIC_HOST", 32'h0},
  parameter int HOST_LEN = 12,
  parameter logic [8*ctps_pkg::STR_MAX-1:0] MOD_NAME = {"GENERIC_MODULE", 16'h0},
  parameter int MOD_LEN = 14
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Personality control
  output logic card_if_select,
  output logic switch_pending,
  output logic level_irq_mode,
  output logic soft_reset_pulse
);
  import ctps_pkg::*;

  // Names must fit the string slots and the whole chain must fit the window
  initial
  begin
    if (HOST_LEN < 1 || HOST_LEN > STR_MAX || MOD_LEN < 1 || MOD_LEN > STR_MAX)
    begin
      $error("ctps_top: name length out of range");
    end
    if (HOST_LEN + MOD_LEN + 9 > CIS_MAX)
    begin
      $error("ctps_top: information chain too long");
    end
    if (SWITCH_WAIT_CYC >= (1 << WAIT_CNT_W))
    begin
      $error("ctps_top: wait counter too narrow");
    end
  end

  // The only value that requests the personality change
  function automatic logic cfg_matches(input logic [7:0] v);
    return (v[SOFT_RESET_BIT] == 1'b0)
        && (v[LEVEL_IRQ_BIT] == 1'b1)
        && (v[FUNC_IDX_MSB:0] == CFG_ENTRY_INDEX[FUNC_IDX_MSB:0]);
  endfunction

  function automatic logic in_cis(input logic [11:0] a);
    return (a >= ADDR_CIS_BASE) && (a <= ADDR_CIS_LAST) && (a[1:0] == 2'b00);
  endfunction

  logic [7:0] cfg_opt_ff;
  logic [7:0] nxt_cfg_opt;
  ctps_mode_e mode_ff;
  ctps_mode_e nxt_mode;
  logic [WAIT_CNT_W-1:0] wait_cnt_ff;
  logic [WAIT_CNT_W-1:0] nxt_wait_cnt;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic card_if_ff;
  logic nxt_card_if;
  logic pending_ff;
  logic nxt_pending;
  logic level_irq_ff;
  logic nxt_level_irq;
  logic soft_reset_ff;
  logic nxt_soft_reset;
  logic [7:0] cis_data;
  logic wr_cfg;

  // Constant tail of the information chain
  ctps_cis_rom #(
    .HOST_NAME(HOST_NAME),
    .HOST_LEN(HOST_LEN),
    .MOD_NAME(MOD_NAME),
    .MOD_LEN(MOD_LEN)
  ) u_rom (
    .idx(paddr[CIS_IDX_W+1:2]),
    .data(cis_data)
  );

  // A write lands only at the completing edge of the access phase
  assign wr_cfg = psel && penable && pready_ff && pwrite && (paddr == ADDR_CFG_OPT) && pstrb[0];

  // Bus answer: one wait state, read data and error prepared with pready
  always_comb
  begin
    nxt_pready = psel && penable && !pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff)
    begin
      nxt_prdata = 32'h0;
      if (paddr == ADDR_CFG_OPT)
      begin
        nxt_prdata = {24'h0, cfg_opt_ff};
      end
      else if (paddr == ADDR_STATUS)
      begin
        nxt_prdata[STAT_PENDING_BIT] = pending_ff;
        nxt_prdata[STAT_SWITCHED_BIT] = card_if_ff;
      end
      else if (in_cis(paddr))
      begin
        nxt_prdata = {24'h0, cis_data};
      end
      else
      begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  // Configuration register and personality state
  always_comb
  begin
    nxt_cfg_opt = cfg_opt_ff;
    nxt_mode = mode_ff;
    nxt_wait_cnt = wait_cnt_ff;
    nxt_soft_reset = 1'b0;
    if (mode_ff == MODE_WAIT)
    begin
      if (wait_cnt_ff != '0)
      begin
        nxt_wait_cnt = wait_cnt_ff - 1'b1;
      end
      else
      begin
        nxt_mode = MODE_CARD_IF;
      end
    end
    if (wr_cfg)
    begin
      nxt_cfg_opt = pwdata[7:0];
      if (pwdata[SOFT_RESET_BIT])
      begin
        // Soft reset returns the card to its PC Card personality and clears the register
        nxt_cfg_opt = CFG_OPT_RESET;
        nxt_mode = MODE_PCCARD;
        nxt_soft_reset = 1'b1;
      end
      else if (mode_ff != MODE_CARD_IF)
      begin
        if (cfg_matches(pwdata[7:0]))
        begin
          nxt_mode = MODE_WAIT;
          nxt_wait_cnt = WAIT_CNT_W'(SWITCH_WAIT_CYC);
        end
        else
        begin
          nxt_mode = MODE_PCCARD;
        end
      end
    end
    nxt_card_if = (nxt_mode == MODE_CARD_IF);
    nxt_pending = (nxt_mode == MODE_WAIT);
    nxt_level_irq = nxt_cfg_opt[LEVEL_IRQ_BIT];
  end

  // Registers only; all outputs come straight from here
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_opt_ff <= CFG_OPT_RESET;
      mode_ff <= MODE_PCCARD;
      wait_cnt_ff <= '0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      card_if_ff <= 1'b0;
      pending_ff <= 1'b0;
      level_irq_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end
    else
    begin
      cfg_opt_ff <= nxt_cfg_opt;
      mode_ff <= nxt_mode;
      wait_cnt_ff <= nxt_wait_cnt;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      card_if_ff <= nxt_card_if;
      pending_ff <= nxt_pending;
      level_irq_ff <= nxt_level_irq;
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign card_if_select = card_if_ff;
  assign switch_pending = pending_ff;
  assign level_irq_mode = level_irq_ff;
  assign soft_reset_pulse = soft_reset_ff;

endmodule

/* verif/ctps_top_sva.sv */
/*
  Port checker for ctps_top: bus answer timing and the personality switch.
  Assumes the bind in the bench top file and one clock domain.
*/
`timescale 1ns/10ps
module ctps_top_sva
  import ctps_pkg::*;
#(
  parameter logic [7:0] CFG_ENTRY_INDEX = 8'h01
)
(
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Personality control
  input wire logic card_if_select,
  input wire logic switch_pending,
  input wire logic level_irq_mode,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] run_ff;
  logic [7:0] nxt_run;
  // Pending run length; saturates so a long run never wraps to zero
  always_comb
  begin
    nxt_run = switch_pending ? run_ff + 8'(run_ff != 8'hff) : 8'h00;
  end
  always_ff @(posedge clk_sys)
  begin
    run_ff <= rst_n ? nxt_run : 8'h00;
  end
  localparam logic [7:0] GOOD_VAL = {2'b01, CFG_ENTRY_INDEX[5:0]};
  // Completing edge of a write to the option register
  sequence cfg_wr;
    psel && penable && pready && pwrite && paddr == ADDR_CFG_OPT && pstrb[0];
  endsequence
  // Write that leaves the soft reset bit clear
  sequence keep_wr;
    cfg_wr ##0 !pwdata[SOFT_RESET_BIT];
  endsequence
  sequence good_wr;
    keep_wr ##0 (pwdata[7:0] == GOOD_VAL && !card_if_select);
  endsequence
  sequence bad_wr;
    keep_wr ##0 (pwdata[7:0] != GOOD_VAL);
  endsequence
  sequence srst_wr;
    cfg_wr ##0 pwdata[SOFT_RESET_BIT];
  endsequence
  // One pulse with both personality flags already cleared
  sequence srst_out;
    soft_reset_pulse && !card_if_select && !switch_pending ##1 !soft_reset_pulse;
  endsequence
  wait_min_a: assert property ($rose(card_if_select) |-> run_ff >= 8'(SWITCH_WAIT_CYC))
    else $error("card interface selected too early");
  ready_once_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  lvl_follow_a: assert property (keep_wr |=>
    level_irq_mode == $past(pwdata[LEVEL_IRQ_BIT]))
    else $error("level interrupt mode not taken");
  start_match_a: assert property (good_wr |=> switch_pending)
    else $error("matching write did not start wait");
  no_start_a: assert property (bad_wr |=> !switch_pending)
    else $error("wrong value started wait");
  soft_pulse_a: assert property (srst_wr |=> srst_out)
    else $error("soft reset not one pulse");
endmodule

/* verif/ctps_host_model.sv */
/*
  Host bus controller model: APB master for tuple reads and option writes.
  Assumes one caller at a time, on the slave's clock.
*/
`timescale 1ns/10ps
module ctps_host_model
(
  // Clock and answer
  input wire logic clk_sys,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Request
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // Idle bus from time zero
  initial
  begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // Request held until pready is seen at an edge; gives up after 16 edges
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r, output logic e, output logic t);
    t = 1'b1;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int n = 0; n < 16 && t; n++)
    begin
      @(posedge clk_sys);
      t = pready !== 1'b1;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines flip so a stale value cannot pass for a fresh one
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* verif/ctps_top_tb_top.sv */
/*
  Bench top for ctps_top with the host model and the bound checker.
  Assumes the ctps_top default names and the package codes.
*/
`timescale 1ns/10ps
module ctps_top_tb_top;
  import ctps_pkg::*;
  localparam logic [7:0] ENTRY = 8'h01;
  localparam logic [7:0] GOOD = {1'b0, 1'b1, ENTRY[5:0]};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr, hung;
  logic card_if_select, switch_pending, level_irq_mode, soft_reset_pulse;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] exp_q[$];
  string hn = "GENERIC_HOST";
  string mn = "GENERIC_MODULE";
  int num_errors = 0;
  int total_checks = 0;
  int n;
  // 10 MHz clock
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  ctps_top #(.CFG_ENTRY_INDEX(ENTRY)) u_dut (.clk_sys, .rst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .card_if_select,
    .switch_pending, .level_irq_mode, .soft_reset_pulse);
  ctps_host_model u_host (.clk_sys, .prdata, .pready, .pslverr, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb);
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // A hung transfer ends the run at once
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    u_host.xfer(w, a, {24'h0, d}, s, rdat, rerr, hung);
    if (hung !== 1'b0)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, hung, 1'b0);
      stop_test();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 8'h00, 4'hf);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Expected chain worked out from the names
    exp_q = {CODE_SYS_EVENT, 8'(hn.len() + 2)};
    foreach (hn[i])
      exp_q.push_back(hn[i]);
    exp_q = {exp_q, STR_TERM, STR_PAD, CODE_PHYS_DEV, 8'(mn.len() + 2)};
    foreach (mn[i])
      exp_q.push_back(mn[i]);
    exp_q = {exp_q, STR_TERM, STR_PAD, CODE_END_CHAIN};
    for (int i = 0; i < exp_q.size() + 2; i++)
    begin
      rd(ADDR_CIS_BASE + 12'(4 * i));
      chk(rdat, {24'h0, i < exp_q.size() ? exp_q[i] : CODE_END_CHAIN});
    end
    rd(ADDR_CFG_OPT);
    chk(rdat, {24'h0, CFG_OPT_RESET});
    rd(12'h008);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // Wrong index is stored but starts nothing
    bus(1'b1, ADDR_CFG_OPT, GOOD ^ 8'h3f, 4'hf);
    rd(ADDR_CFG_OPT);
    chk({rdat[30:0], switch_pending}, {23'h0, GOOD ^ 8'h3f, 1'b0});
    // Matching value without its byte strobe, or sent to status, is ignored
    bus(1'b1, ADDR_CFG_OPT, GOOD, 4'h0);
    bus(1'b1, ADDR_STATUS, GOOD, 4'hf);
    chk({31'h0, rerr}, 32'h0);
    rd(ADDR_CFG_OPT);
    chk({rdat[30:0], switch_pending}, {23'h0, GOOD ^ 8'h3f, 1'b0});
    // A wrong value during the wait cancels it for good
    bus(1'b1, ADDR_CFG_OPT, GOOD, 4'hf);
    @(negedge clk_sys);
    chk({31'h0, switch_pending}, 32'h1);
    bus(1'b1, ADDR_CFG_OPT, GOOD ^ 8'h01, 4'hf);
    repeat (110) @(negedge clk_sys);
    chk({30'h0, switch_pending, card_if_select}, 32'h0);
    bus(1'b1, ADDR_CFG_OPT, GOOD, 4'hf);
    @(negedge clk_sys);
    chk({30'h0, switch_pending, level_irq_mode}, 32'h3);
    n = 0;
    while (card_if_select !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, n >= 100 && n < 300}, 32'h1);
    rd(ADDR_STATUS);
    chk(rdat, 32'h2);
    // In card mode a plain write only updates the register
    bus(1'b1, ADDR_CFG_OPT, 8'h01, 4'hf);
    @(negedge clk_sys);
    chk({29'h0, card_if_select, switch_pending, level_irq_mode}, 32'h4);
    rd(ADDR_CFG_OPT);
    chk(rdat, 32'h1);
    bus(1'b1, ADDR_CFG_OPT, 8'h80, 4'hf);
    @(negedge clk_sys);
    chk({29'h0, soft_reset_pulse, card_if_select, switch_pending}, 32'h4);
    @(negedge clk_sys);
    chk({31'h0, soft_reset_pulse}, 32'h0);
    rd(ADDR_CFG_OPT);
    chk({rdat[29:0], card_if_select, level_irq_mode}, 32'h0);
    stop_test();
  end
endmodule
bind ctps_top ctps_top_sva #(.CFG_ENTRY_INDEX(CFG_ENTRY_INDEX)) u_sva (.clk_sys, .rst_n,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .card_if_select, .switch_pending, .level_irq_mode, .soft_reset_pulse);
